// File: hw/acpc_pkg.sv
// Purpose: Shared constants and types for the conversion and power control block.
// Assumes: 50 MHz system clock, all pin inputs synchronous to it.
// Notes: Times are kept in their printed units and turned into cycle counts here.
package acpc_pkg;

    localparam int CLK_PERIOD_NS = 20;
    // Longest conversion time; a longest time rounds down to whole cycles.
    localparam int CONV_TIME_NS = 550;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    // Start-up wait after power-down release or power-on reset.
    localparam int STARTUP_TIME_MS = 10;
    localparam int STARTUP_CYCLES = STARTUP_TIME_MS * 1000000 / CLK_PERIOD_NS;
    // Internal reset pulse length after a global reset request.
    localparam int GRESET_TIME_NS = 100;
    localparam int GRESET_CYCLES = (GRESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CONV_CNT_W = 6;
    localparam int WAIT_CNT_W = 20;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
    localparam logic [CONV_CNT_W-1:0] GRESET_LAST = CONV_CNT_W'(GRESET_CYCLES - 1);

    // Operating states of the converter core.
    typedef enum logic [2:0] {
        ACPC_ST_INIT = 3'h0,
        ACPC_ST_ACQ = 3'h1,
        ACPC_ST_CONV = 3'h2,
        ACPC_ST_NAP = 3'h3,
        ACPC_ST_PDOWN = 3'h4,
        ACPC_ST_GRST = 3'h5
    } acpc_state_t;

    // Pin-side status bundle driven by the core.
    typedef struct packed {
        logic busy;
        logic hold;
        logic nap;
        logic powered_down;
        logic window_open;
        logic ready;
    } acpc_status_t;

endpackage : acpc_pkg

// File: hw/acpc_edge_det.sv
// Purpose: Registers a level and reports its rising edge as a one-cycle pulse.
// Assumes: Input is already synchronous to clock.
// Notes: The pulse is combinational from the registered history and the live input.
`timescale 1ns/1ps
`default_nettype none
module acpc_edge_det
    import acpc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic level,
    output logic rise
);

    typedef struct packed {
        logic prev;
    } acpc_edge_state_t;

    acpc_edge_state_t s_r;
    acpc_edge_state_t s_nxt;

    // Remember the level from the previous cycle.
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.prev = level;
    end

    // State register.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // High for the cycle in which the level has just gone from low to high.
    assign rise = level & ~s_r.prev;

endmodule : acpc_edge_det
`default_nettype wire

// File: hw/acpc_wait_timer.sv
// Purpose: Counts down a start-up wait and reports when it has run out.
// Assumes: load restarts the full wait; done is a level.
// Notes: The length is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`default_nettype none
module acpc_wait_timer
    import acpc_pkg::*;
#(
    parameter int WAIT_CYCLES = STARTUP_CYCLES
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic load,
    output logic done
);

    typedef struct packed {
        logic [WAIT_CNT_W-1:0] cnt;
    } acpc_timer_state_t;

    acpc_timer_state_t s_r;
    acpc_timer_state_t s_nxt;

    // Reload on request, otherwise count down to zero and stop.
    always_comb
    begin
        s_nxt = s_r;
        if (load)
        begin
            s_nxt.cnt = WAIT_CNT_W'(WAIT_CYCLES);
        end
        else if (s_r.cnt != '0)
        begin
            s_nxt.cnt = s_r.cnt - WAIT_CNT_W'(1);
        end
    end

    // Starts full so that the wait also applies from power-up.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r.cnt <= WAIT_CNT_W'(WAIT_CYCLES);
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign done = (s_r.cnt == '0);

endmodule : acpc_wait_timer
`default_nettype wire

// File: hw/acpc_core.sv
// Purpose: Conversion sequencing, nap and power-down control of the converter.
// Assumes: convert_start and power_down_request are synchronous to clock.
// Notes: Busy, hold and status outputs are all registered.
//
// Behaviour
// - Convert-start rising edge moves sample-and-hold to hold and starts a conversion.
// - A started conversion always completes unless a global reset or low supply aborts it.
// - Busy rises at conversion start and falls when the conversion ends.
// - Every conversion ends within 550 ns on the internal clock.
// - Exactly one channel converts per convert-start edge.
// - Convert-start still high after a conversion puts the device into nap.
// - In nap use, acquisition lasts while convert-start is low.
// - While power-down is high, the device stays down and ignores starts.
// - Power-down during a conversion takes effect only after it completes.
// - Power-on reset at power-up or low supply, reinitialise afterwards.
// - Two power-down rises with no conversion between trigger a global reset.
// - A new data window opens when a conversion completes, not when a reset drops busy.
`timescale 1ns/1ps
`default_nettype none
module acpc_core
    import acpc_pkg::*;
#(
    parameter int WAIT_CYCLES = STARTUP_CYCLES
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic convert_start,
    input wire logic power_down_request,
    input wire logic supply_low,
    output logic busy,
    output logic sample_hold,
    output logic nap_active,
    output logic powered_down,
    output logic window_open,
    output logic startup_done,
    output logic global_reset_active,
    output logic conversion_done
);

    // Core state apart from the pin history and the timer: sequence, counter, power-down tracking and registered status.
    typedef struct packed {
        acpc_state_t state;
        logic [CONV_CNT_W-1:0] cnt;
        logic pd_armed;
        logic pd_pending;
        acpc_status_t stat;
        logic greset;
        logic done_pulse;
        logic por_seen;
    } acpc_core_state_t;

    // Registered state, its next value and the pin-side helper signals.
    acpc_core_state_t s_r;
    acpc_core_state_t s_nxt;
    logic cnv_rise;
    logic pd_rise;
    logic pd_fall;
    logic pd_prev_r;
    logic timer_load;
    logic timer_done;

    // Advances a cycle counter by one; shared by conversion and reset timing.
    function automatic logic [CONV_CNT_W-1:0] acpc_step(input logic [CONV_CNT_W-1:0] cnt);
        acpc_step = cnt + CONV_CNT_W'(1);
    endfunction : acpc_step

    // Drops a conversion in flight, with any power-down it was holding back.
    function automatic acpc_core_state_t acpc_halt(input acpc_core_state_t s);
        acpc_halt = s;
        acpc_halt.cnt = '0;
        acpc_halt.stat.busy = 1'b0;
        acpc_halt.stat.hold = 1'b0;
        acpc_halt.pd_pending = 1'b0;
    endfunction : acpc_halt

    // One rising-edge detector per control pin: bit 0 start, bit 1 power-down.
    logic [1:0] pin_level;
    logic [1:0] pin_rise;

    assign pin_level = {power_down_request, convert_start};
    assign cnv_rise = pin_rise[0];
    assign pd_rise = pin_rise[1];

    generate
        for (genvar i = 0; i < $bits(pin_level); i++)
        begin : g_edge
            acpc_edge_det u_edge (
                .clock(clock),
                .nrst(nrst),
                .level(pin_level[i]),
                .rise(pin_rise[i])
            );
        end
    endgenerate

    // Settling timer; it reports only and never blocks a start.
    acpc_wait_timer #(
        .WAIT_CYCLES(WAIT_CYCLES)
    ) u_wait (
        .clock(clock),
        .nrst(nrst),
        .load(timer_load),
        .done(timer_done)
    );

    // Falling edge of power-down restarts the settling wait.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pd_prev_r <= 1'b0;
        end
        else
        begin
            pd_prev_r <= power_down_request;
        end
    end

    // The wait restarts on power-down release, low supply or an internal reset.
    assign pd_fall = pd_prev_r & ~power_down_request;
    assign timer_load = pd_fall | supply_low | s_r.greset;

    // Next-state logic for the converter sequence.
    always_comb
    begin
        // Pulses default low; everything else holds unless a branch moves it.
        s_nxt = s_r;
        s_nxt.done_pulse = 1'b0;
        s_nxt.stat.window_open = 1'b0;
        // A second power-down rise with no conversion since the first resets all.
        if (pd_rise)
        begin
            s_nxt.pd_armed = 1'b1;
        end
        // Second rise while armed: drop everything and run the internal reset.
        if (pd_rise && s_r.pd_armed && s_r.state != ACPC_ST_GRST)
        begin
            s_nxt = acpc_halt(s_nxt);
            s_nxt.state = ACPC_ST_GRST;
            s_nxt.greset = 1'b1;
            s_nxt.pd_armed = 1'b0;
        end
        // Low supply acts as a power-on reset and cuts short a running internal reset; a second power-down rise in the same cycle wins.
        else if (supply_low)
        begin
            s_nxt = acpc_halt(s_nxt);
            s_nxt.state = ACPC_ST_INIT;
            s_nxt.greset = 1'b0;
            s_nxt.pd_armed = 1'b0;
        end
        else
        begin
            case (s_r.state)
                ACPC_ST_INIT:
                begin
                    // Leave initialisation for the idle state that the pin asks for.
                    if (power_down_request)
                    begin
                        s_nxt.state = ACPC_ST_PDOWN;
                    end
                    else
                    begin
                        s_nxt.state = ACPC_ST_ACQ;
                    end
                end
                ACPC_ST_ACQ:
                begin
                    // Tracking; acquisition lasts until the next start edge.
                    if (power_down_request)
                    begin
                        s_nxt.state = ACPC_ST_PDOWN;
                    end
                    else if (cnv_rise)
                    begin
                        s_nxt.state = ACPC_ST_CONV;
                        s_nxt.cnt = '0;
                        s_nxt.stat.hold = 1'b1;
                        s_nxt.stat.busy = 1'b1;
                        s_nxt.pd_armed = 1'b0;
                    end
                end
                ACPC_ST_CONV:
                begin
                    // Further start edges and power-down do not cut this short.
                    if (pd_rise || power_down_request)
                    begin
                        s_nxt.pd_pending = 1'b1;
                    end
                    // Last cycle: drop busy, open the data window and pick what follows.
                    if (s_r.cnt == CONV_LAST)
                    begin
                        s_nxt.stat.busy = 1'b0;
                        s_nxt.stat.hold = 1'b0;
                        s_nxt.done_pulse = 1'b1;
                        s_nxt.stat.window_open = 1'b1;
                        if (s_r.pd_pending || power_down_request)
                        begin
                            s_nxt.state = ACPC_ST_PDOWN;
                        end
                        else if (convert_start)
                        begin
                            s_nxt.state = ACPC_ST_NAP;
                        end
                        else
                        begin
                            s_nxt.state = ACPC_ST_ACQ;
                        end
                        s_nxt.pd_pending = 1'b0;
                    end
                    else
                    begin
                        s_nxt.cnt = acpc_step(s_r.cnt);
                    end
                end
                ACPC_ST_NAP:
                begin
                    // Sampling circuits are off until convert-start goes low.
                    if (power_down_request)
                    begin
                        s_nxt.state = ACPC_ST_PDOWN;
                    end
                    else if (!convert_start)
                    begin
                        s_nxt.state = ACPC_ST_ACQ;
                    end
                end
                ACPC_ST_PDOWN:
                begin
                    // Starts are ignored here; only releasing power-down, low supply or a second power-down rise while armed leaves.
                    if (!power_down_request)
                    begin
                        s_nxt.state = ACPC_ST_ACQ;
                    end
                end
                ACPC_ST_GRST:
                begin
                    // Internal reset pulse runs out on its own timer.
                    if (s_r.cnt == GRESET_LAST)
                    begin
                        s_nxt.greset = 1'b0;
                        if (power_down_request)
                        begin
                            s_nxt.state = ACPC_ST_PDOWN;
                        end
                        else
                        begin
                            s_nxt.state = ACPC_ST_ACQ;
                        end
                    end
                    else
                    begin
                        s_nxt.cnt = acpc_step(s_r.cnt);
                    end
                end
                // An illegal code restarts cleanly with no conversion in flight.
                default:
                begin
                    s_nxt = acpc_halt(s_nxt);
                    s_nxt.state = ACPC_ST_INIT;
                end
            endcase
        end
        // Status flags follow the state being entered.
        s_nxt.stat.nap = (s_nxt.state == ACPC_ST_NAP);
        s_nxt.stat.powered_down = (s_nxt.state == ACPC_ST_PDOWN);
        s_nxt.stat.ready = timer_done & ~s_nxt.greset;
    end

    // State register.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r <= '0;
            s_r.state <= ACPC_ST_INIT;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign busy = s_r.stat.busy;
    assign sample_hold = s_r.stat.hold;
    assign nap_active = s_r.stat.nap;
    assign powered_down = s_r.stat.powered_down;
    assign window_open = s_r.stat.window_open;
    assign startup_done = s_r.stat.ready;
    assign global_reset_active = s_r.greset;
    assign conversion_done = s_r.done_pulse;

endmodule : acpc_core
`default_nettype wire

// File: verif/acpc_host_model.sv
// Purpose: Host controller model that drives the start and power-down pins.
// Assumes: Bench commands change on the falling clock edge.
// Notes: A start stays high two cycles (40 ns) unless nap is wanted.
`timescale 1ns/1ps
`default_nettype none
module acpc_host_model
(
    input wire logic clock,
    input wire logic go,
    input wire logic nap_keep,
    input wire logic pd_cmd,
    output var logic convert_start,
    output var logic power_down_request
);
    logic [1:0] hi_cnt;

    // Pins start low so no edge is seen before the bench asks for one.
    initial
    begin
        convert_start = 1'b0;
        power_down_request = 1'b0;
        hi_cnt = 2'h0;
    end

    // Pins move on the falling edge, well away from the core's sampling edge.
    always @(negedge clock)
    begin
        power_down_request <= pd_cmd;
        if (go && !convert_start)
        begin
            convert_start <= 1'b1;
            hi_cnt <= 2'h0;
        end
        else if (convert_start && !nap_keep && hi_cnt == 2'h1)
            convert_start <= 1'b0;
        else
            hi_cnt <= hi_cnt + 2'h1;
    end
endmodule : acpc_host_model
`default_nettype wire

// File: verif/acpc_core_properties.sv
// Purpose: Port timing checks for the conversion core.
// Assumes: One clock domain, reset active low.
// Notes: Bound to the core from the bench top.
`timescale 1ns/1ps
`default_nettype none
module acpc_core_properties
    import acpc_pkg::*;
#(
    parameter int WAIT_CYCLES = STARTUP_CYCLES
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic convert_start,
    input wire logic power_down_request,
    input wire logic supply_low,
    input wire logic busy,
    input wire logic sample_hold,
    input wire logic nap_active,
    input wire logic powered_down,
    input wire logic window_open,
    input wire logic startup_done,
    input wire logic global_reset_active,
    input wire logic conversion_done
);
    logic [5:0] busy_cnt_r;

    // Counts busy cycles so a short or long conversion shows at the fall.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            busy_cnt_r <= 6'h00;
        else
            busy_cnt_r <= busy ? busy_cnt_r + 6'h01 : 6'h00;
    end

    // All checks share the core clock and reset.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_start_takes: assert property (
        $rose(convert_start) && !busy && !$past(busy) && !nap_active && !powered_down && !global_reset_active
        && !power_down_request && !supply_low && startup_done |=> busy && sample_hold) else $error("start missed");
    a_busy_length: assert property (
        $fell(busy) && !global_reset_active && !$past(supply_low) |-> busy_cnt_r == 6'(CONV_CYCLES))
        else $error("busy length");
    a_busy_bound: assert property (busy_cnt_r <= 6'(CONV_CYCLES)) else $error("busy too long");
    a_hold_busy: assert property (sample_hold == busy) else $error("hold not busy");
    a_window_pulse: assert property (
        $fell(busy) && !global_reset_active && !$past(supply_low)
        |-> window_open && conversion_done ##1 !window_open && !conversion_done) else $error("window pulse");
    a_nap_entry: assert property (
        $fell(busy) && convert_start && !power_down_request && !global_reset_active && !$past(supply_low)
        |-> ##[0:1] nap_active) else $error("no nap");
    a_nap_leave: assert property (nap_active && !convert_start |-> ##[1:2] !nap_active) else $error("nap stuck");
    a_pd_quiet: assert property (powered_down && power_down_request |=> !busy) else $error("start in pd");
    a_pd_waits: assert property (busy |-> !powered_down) else $error("pd mid conversion");
    a_greset_len: assert property (
        $rose(global_reset_active) |-> !busy throughout (global_reset_active[*5] ##1 !global_reset_active))
        else $error("reset pulse");
    a_supply_clear: assert property (supply_low |=> !busy ##1 !startup_done) else $error("supply reset");

    c_conv: cover property ($fell(busy));
    c_nap: cover property ($rose(nap_active));
    c_greset: cover property ($rose(global_reset_active));
endmodule : acpc_core_properties
`default_nettype wire

// File: verif/acpc_core_tb.sv
// Purpose: Self-checking bench for the conversion and power control core.
// Assumes: Start-up wait shortened to 50 cycles.
// Notes: The host model drives the pins; the bench commands it.
`timescale 1ns/1ps
`default_nettype none
module acpc_core_tb;
    localparam int WAIT_SIM = 50;
    logic clock, nrst, supply_low, go, nap_keep, pd_cmd;
    logic convert_start, power_down_request, busy, sample_hold, nap_active, powered_down;
    logic window_open, startup_done, global_reset_active, conversion_done;
    int fails, n_checks;

    acpc_core #(.WAIT_CYCLES(WAIT_SIM)) u_dut (.clock, .nrst, .convert_start, .power_down_request,
        .supply_low, .busy, .sample_hold, .nap_active, .powered_down, .window_open, .startup_done,
        .global_reset_active, .conversion_done);
    acpc_host_model u_host (.clock, .go, .nap_keep, .pd_cmd, .convert_start, .power_down_request);

    task automatic end_of_test();
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic wait_busy(input logic v);
        int i;
        for (i = 0; i < 200 && busy !== v; i++)
            @(negedge clock);
        chk("busy wait", busy, v);
        if (busy !== v)
            end_of_test();
    endtask : wait_busy

    // Waits out the start-up period before any further start.
    task automatic settle();
        repeat (3) @(negedge clock);
        chk("startup early", startup_done, 1'b0);
        repeat (WAIT_SIM + 10) @(negedge clock);
        chk("startup", startup_done, 1'b1);
    endtask : settle

    // One conversion; optionally a stray start or power-down midway.
    task automatic conv(input logic mid_go, input logic pd);
        int n;
        go <= 1'b1;
        @(negedge clock);
        go <= 1'b0;
        wait_busy(1'b1);
        chk("hold", sample_hold, 1'b1);
        for (n = 0; n < 40 && busy === 1'b1; n++)
        begin
            go <= mid_go && n == 5;
            if (n == 5)
                pd_cmd <= pd;
            @(negedge clock);
        end
        chk("busy cycles", 8'(n), 8'(acpc_pkg::CONV_CYCLES));
        if (n == 40)
            end_of_test();
        chk("window", window_open, 1'b1);
        chk("done", conversion_done, 1'b1);
        chk("pd at end", powered_down, pd);
        repeat (40) @(negedge clock);
        chk("one per edge", busy, 1'b0);
    endtask : conv

    task automatic t_nap();
        nap_keep <= 1'b1;
        conv(1'b0, 1'b0);
        chk("nap", nap_active, 1'b1);
        nap_keep <= 1'b0;
        repeat (42) @(negedge clock);
        chk("nap left", nap_active, 1'b0);
        conv(1'b0, 1'b0);
    endtask : t_nap

    // Power-down held back by a conversion, then a start that must be ignored.
    task automatic t_pd();
        int n;
        conv(1'b0, 1'b1);
        go <= 1'b1;
        @(negedge clock);
        go <= 1'b0;
        for (n = 0; n < 30; n++)
        begin
            @(negedge clock);
            chk("start in pd", busy, 1'b0);
        end
        chk("pd held", powered_down, 1'b1);
        pd_cmd <= 1'b0;
        settle();
        chk("pd off", powered_down, 1'b0);
    endtask : t_pd

    // A second power-down rise without a start between aborts the conversion.
    task automatic t_greset();
        int n;
        go <= 1'b1;
        @(negedge clock);
        go <= 1'b0;
        wait_busy(1'b1);
        pd_cmd <= 1'b1;
        repeat (3) @(negedge clock);
        pd_cmd <= 1'b0;
        repeat (3) @(negedge clock);
        pd_cmd <= 1'b1;
        for (n = 0; n < 5 && global_reset_active !== 1'b1; n++)
            @(negedge clock);
        chk("abort", busy, 1'b0);
        for (n = 0; n < 20 && global_reset_active === 1'b1; n++)
            @(negedge clock);
        chk("reset len", 8'(n), 8'(acpc_pkg::GRESET_CYCLES));
        if (n == 20)
            end_of_test();
        chk("pd kept", powered_down, 1'b1);
        pd_cmd <= 1'b0;
        settle();
    endtask : t_greset

    // Low supply cuts a conversion that holds back a power-down; nothing of it may survive.
    task automatic t_supply();
        go <= 1'b1;
        @(negedge clock);
        go <= 1'b0;
        wait_busy(1'b1);
        pd_cmd <= 1'b1;
        repeat (2) @(negedge clock);
        supply_low <= 1'b1;
        repeat (2) @(negedge clock);
        chk("supply abort", busy, 1'b0);
        supply_low <= 1'b0;
        pd_cmd <= 1'b0;
        settle();
        conv(1'b0, 1'b0);
    endtask : t_supply

    // Free-running 50 MHz clock.
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Reset, then each scenario in turn.
    initial
    begin
        nrst = 1'b0;
        supply_low = 1'b0;
        go = 1'b0;
        nap_keep = 1'b0;
        pd_cmd = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (5) @(negedge clock);
        chk("busy in reset", busy, 1'b0);
        nrst <= 1'b1;
        settle();
        conv(1'b1, 1'b0);
        t_nap();
        t_pd();
        t_greset();
        t_supply();
        end_of_test();
    end
endmodule : acpc_core_tb

bind acpc_core acpc_core_properties #(.WAIT_CYCLES(WAIT_CYCLES)) u_props (.clock, .nrst, .convert_start,
    .power_down_request, .supply_low, .busy, .sample_hold, .nap_active, .powered_down, .window_open,
    .startup_done, .global_reset_active, .conversion_done);
`default_nettype wire
